// >>> common/vcsm_defs.svh
// constants of the valve channel status and mask register slice
// assumes a 40 MHz core clock and a 20-bit register word
`ifndef VCSM_DEFS_SVH
`define VCSM_DEFS_SVH

// register offsets within the channel
`define VCSM_ADDR_W 4
`define VCSM_ADDR_INTG 4'h8
`define VCSM_ADDR_AVG 4'h9
`define VCSM_ADDR_INST 4'ha
`define VCSM_ADDR_PWMS 4'hb
`define VCSM_ADDR_MASK 4'hc

// reset values
`define VCSM_WORD_W 20
`define VCSM_INTG_RST 20'h00091
`define VCSM_MASK_RST 20'h09fff
`define VCSM_PWMS_RST 20'h04000

// field layout
`define VCSM_INTG_W 8
`define VCSM_STEADY_HI 7
`define VCSM_STEADY_LO 4
`define VCSM_TRANS_HI 3
`define VCSM_TRANS_LO 0
`define VCSM_LIMIT_W 4
`define VCSM_AVG_W 11
`define VCSM_INST_W 12
`define VCSM_CODE_W 18
`define VCSM_PERIOD_TIMEOUT_FLAG_BIT 18
`define VCSM_MASK_W 16
`define VCSM_MASK_TW 15
`define VCSM_MASK_CRC_CSA 14
`define VCSM_MASK_CRC_CONV 13
`define VCSM_IRQ_BITS 16'h9fff

// timing
`define VCSM_CLK_PERIOD_NS 25
`define VCSM_STEP_NS 125
`define VCSM_STEP_CYCLES ((`VCSM_STEP_NS + `VCSM_CLK_PERIOD_NS - 1) / `VCSM_CLK_PERIOD_NS)
`define VCSM_CODE_MIN 18'h00008
`define VCSM_CODE_MAX 18'h3fff0

`endif

// >>> common/vcsm_pkg.sv
// types of the valve channel status and mask register slice
// assumes vcsm_defs.svh on the include path
`include "vcsm_defs.svh"

package vcsm_pkg;

   typedef logic [`VCSM_WORD_W-1:0] vcsm_word_type;
   typedef logic [`VCSM_CODE_W-1:0] vcsm_code_type;

   typedef enum logic [`VCSM_ADDR_W-1:0]
   {
      VCSM_REG_INTG = `VCSM_ADDR_INTG,
      VCSM_REG_AVG = `VCSM_ADDR_AVG,
      VCSM_REG_INST = `VCSM_ADDR_INST,
      VCSM_REG_PWMS = `VCSM_ADDR_PWMS,
      VCSM_REG_MASK = `VCSM_ADDR_MASK
   } vcsm_reg_type;

endpackage

// >>> common/vcsm_period_if.sv
// carrier between the period meter and the register slice
// assumes both ends run on core_clk_i
`timescale 1ns/10ps
`default_nettype none

interface vcsm_period_if;
   import vcsm_pkg::*;
   vcsm_code_type code;
   logic timeout;
   logic update;

   modport meter (output code, output timeout, output update);
   modport regs (input code, input timeout, input update);
endinterface

`default_nettype wire

// >>> verilog/vcsm_period_meter.sv
// pwm period meter: counts 125 ns steps between rising edges of the
// sensed pwm pin; assumes the pin is asynchronous to core_clk_i
`timescale 1ns/10ps
`default_nettype none
`include "vcsm_defs.svh"

module vcsm_period_meter
   import vcsm_pkg::*;
(
   // clock and power-on reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // sensed pwm pin
   input wire logic pwm_sense_i,
   // result
   vcsm_period_if.meter per_if
);

   localparam logic [2:0] STEP_LAST = 3'(`VCSM_STEP_CYCLES - 1);

   logic pwm_s1_r;
   logic pwm_s2_r;
   logic pwm_d_r;
   logic [2:0] pre_r;
   vcsm_code_type cnt_r;
   vcsm_code_type code_r;
   logic period_timeout_flag_r;
   logic upd_r;
   logic rise;
   logic tick;
   vcsm_code_type cnt_fin;

   // ***********************************************
   // pin synchroniser and edge detect
   // ***********************************************
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pwm_s1_r <= 1'b0;
         pwm_s2_r <= 1'b0;
         pwm_d_r <= 1'b0;
      end
      else
      begin
         pwm_s1_r <= pwm_sense_i;
         pwm_s2_r <= pwm_s1_r;
         pwm_d_r <= pwm_s2_r;
      end
   end

   assign rise = pwm_s2_r & ~pwm_d_r;
   assign tick = (pre_r == STEP_LAST);
   // a step that ends on the closing edge is still a full step
   assign cnt_fin = (tick && cnt_r != `VCSM_CODE_MAX) ? cnt_r + 18'h00001 : cnt_r;

   // ***********************************************
   // step prescaler and period counter
   // ***********************************************
   // prescaler restarts on each rising edge so the code is not smeared by phase
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         pre_r <= 3'h0;
      else if (rise || tick)
         pre_r <= 3'h0;
      else
         pre_r <= pre_r + 3'h1;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cnt_r <= '0;
      else if (rise)
         cnt_r <= '0;
      else
         cnt_r <= cnt_fin;
   end

   // ***********************************************
   // result and out-of-range flag
   // ***********************************************
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         code_r <= `VCSM_CODE_W'(`VCSM_PWMS_RST);
         period_timeout_flag_r <= 1'b0;
         upd_r <= 1'b0;
      end
      else
      begin
         upd_r <= rise;
         if (rise)
         begin
            code_r <= cnt_fin;
            period_timeout_flag_r <= (cnt_fin < `VCSM_CODE_MIN) || (cnt_fin >= `VCSM_CODE_MAX);
         end
         else if (cnt_r == `VCSM_CODE_MAX)
            period_timeout_flag_r <= 1'b1;
      end
   end

   assign per_if.code = code_r;
   assign per_if.timeout = period_timeout_flag_r;
   assign per_if.update = upd_r;

   // ***********************************************
   // checks
   // ***********************************************
   sequence s_no_edge;
      !rise [*4];
   endsequence

   property p_step_spacing;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (tick && !rise) ##1 s_no_edge |=> tick;
   endproperty
   a_step_spacing: assert property (p_step_spacing) else $error("step tick spacing wrong");

   property p_step_after_edge;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      rise ##1 s_no_edge |=> tick;
   endproperty
   a_step_after_edge: assert property (p_step_after_edge) else $error("first step late");

   property p_short_period;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      rise && (cnt_fin < `VCSM_CODE_MIN) |=> period_timeout_flag_r && upd_r;
   endproperty
   a_short_period: assert property (p_short_period) else $error("short period not flagged");

endmodule

`default_nettype wire

// >>> verilog/vcsm_regs.sv
// per-channel integral limits, current readback, pwm sense and fault mask
// assumes the serial front end gives one-cycle read and write strobes on core_clk_i
// and that fault and supply reset event inputs are asynchronous
`timescale 1ns/10ps
`default_nettype none
`include "vcsm_defs.svh"

module vcsm_regs
   import vcsm_pkg::*;
(
   // clock and power-on reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // register port from the serial front end
   input wire logic [`VCSM_ADDR_W-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [`VCSM_WORD_W-1:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [`VCSM_WORD_W-1:0] reg_rdata_o,
   // supply reset events
   input wire logic battery_undervoltage_event_i,
   input wire logic ground_loss_event_i,
   input wire logic primary_reset_event_i,
   // current loop
   input wire logic hw_feedback_mode_i,
   input wire logic loop_transient_i,
   input wire logic avg_valid_i,
   input wire logic [`VCSM_AVG_W-1:0] average_current_code_i,
   input wire logic inst_valid_i,
   input wire logic [`VCSM_INST_W-1:0] instant_current_value_i,
   output logic [`VCSM_LIMIT_W-1:0] applied_integ_limit_o,
   // sensed pwm pin
   input wire logic pwm_sense_i,
   // faults and interrupt
   input wire logic [`VCSM_MASK_W-1:0] fault_event_i,
   input wire logic gpo_irq_enable_i,
   output logic general_interrupt_output_o,
   output logic calibration_enable_o,
   output logic trimming_enable_o
);

   localparam int SYNC_W = `VCSM_MASK_W + 3;
   localparam logic [`VCSM_MASK_W-1:0] IRQ_BITS = `VCSM_IRQ_BITS;

   logic [SYNC_W-1:0] async_in;
   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   logic [`VCSM_MASK_W-1:0] fault_s;
   logic soft_rst;
   logic [`VCSM_INTG_W-1:0] intg_r;
   logic [`VCSM_MASK_W-1:0] mask_r;
   logic [`VCSM_AVG_W-1:0] avg_r;
   logic [`VCSM_INST_W-1:0] inst_r;
   logic [`VCSM_LIMIT_W-1:0] applied_r;
   logic irq_r;
   logic cal_en_r;
   logic trim_en_r;
   logic [`VCSM_WORD_W-1:0] rdata_r;
   logic [`VCSM_WORD_W-1:0] rd_nxt;
   logic [`VCSM_MASK_W-1:0] fault_pass;
   logic wr_intg;
   logic wr_mask;

   vcsm_period_if per_if ();

   // ***********************************************
   // period meter
   // ***********************************************
   vcsm_period_meter u_meter
   (
      .core_clk_i (core_clk_i),
      .rst_n_i (rst_n_i),
      .pwm_sense_i (pwm_sense_i),
      .per_if (per_if.meter)
   );

   // ***********************************************
   // input synchronisers
   // ***********************************************
   assign async_in = {battery_undervoltage_event_i, ground_loss_event_i,
                      primary_reset_event_i, fault_event_i};

   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi = gi + 1)
      begin : g_sync
         always_ff @(posedge core_clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               sync1_r[gi] <= 1'b0;
               sync2_r[gi] <= 1'b0;
            end
            else
            begin
               sync1_r[gi] <= async_in[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate

   assign fault_s = sync2_r[`VCSM_MASK_W-1:0];
   // power-on is rst_n_i itself; the other events reset only the config
   assign soft_rst = |sync2_r[SYNC_W-1:`VCSM_MASK_W];

   assign wr_intg = reg_wr_i && (reg_addr_i == VCSM_REG_INTG);
   assign wr_mask = reg_wr_i && (reg_addr_i == VCSM_REG_MASK);

   // ***********************************************
   // integrator limits
   // ***********************************************
   // a supply event in the same cycle as a write wins over the write
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         intg_r <= `VCSM_INTG_W'(`VCSM_INTG_RST);
      else if (soft_rst)
         intg_r <= `VCSM_INTG_W'(`VCSM_INTG_RST);
      else if (wr_intg)
         intg_r <= reg_wdata_i[`VCSM_INTG_W-1:0];
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         applied_r <= '0;
      else if (!hw_feedback_mode_i)
         applied_r <= '0;
      else if (loop_transient_i)
         applied_r <= intg_r[`VCSM_TRANS_HI:`VCSM_TRANS_LO];
      else
         applied_r <= intg_r[`VCSM_STEADY_HI:`VCSM_STEADY_LO];
   end

   // ***********************************************
   // fault mask
   // ***********************************************
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         mask_r <= `VCSM_MASK_W'(`VCSM_MASK_RST);
      else if (soft_rst)
         mask_r <= `VCSM_MASK_W'(`VCSM_MASK_RST);
      else if (wr_mask)
         mask_r <= reg_wdata_i[`VCSM_MASK_W-1:0];
   end

   // ***********************************************
   // current readback, power-on reset only
   // ***********************************************
   // no write path: the measured values cannot be overwritten by software
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         avg_r <= '0;
      else if (avg_valid_i)
         avg_r <= average_current_code_i;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         inst_r <= '0;
      else if (inst_valid_i)
         inst_r <= instant_current_value_i;
   end

   // ***********************************************
   // interrupt and calibration gating
   // ***********************************************
   // crc bits 14 and 13 steer calibration and trimming, not the interrupt
   generate
      for (gi = 0; gi < `VCSM_MASK_W; gi = gi + 1)
      begin : g_gate
         assign fault_pass[gi] = fault_s[gi] & ~mask_r[gi] & IRQ_BITS[gi];
      end
   endgenerate

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         irq_r <= 1'b0;
      else
         irq_r <= gpo_irq_enable_i & (|fault_pass);
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cal_en_r <= 1'b1;
         trim_en_r <= 1'b1;
      end
      else
      begin
         cal_en_r <= ~(fault_s[`VCSM_MASK_CRC_CSA] & ~mask_r[`VCSM_MASK_CRC_CSA]);
         trim_en_r <= ~(fault_s[`VCSM_MASK_CRC_CONV] & ~mask_r[`VCSM_MASK_CRC_CONV]);
      end
   end

   // ***********************************************
   // read mux
   // ***********************************************
   always_comb
   begin
      rd_nxt = '0;
      unique case (reg_addr_i)
         VCSM_REG_INTG: rd_nxt[`VCSM_INTG_W-1:0] = intg_r;
         VCSM_REG_AVG: rd_nxt[`VCSM_AVG_W-1:0] = avg_r;
         VCSM_REG_INST: rd_nxt[`VCSM_INST_W-1:0] = inst_r;
         VCSM_REG_PWMS:
         begin
            rd_nxt[`VCSM_CODE_W-1:0] = per_if.code;
            rd_nxt[`VCSM_PERIOD_TIMEOUT_FLAG_BIT] = per_if.timeout;
         end
         VCSM_REG_MASK: rd_nxt[`VCSM_MASK_W-1:0] = mask_r;
         default: rd_nxt = '0;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_r <= '0;
      else if (reg_rd_i)
         rdata_r <= rd_nxt;
   end

   assign reg_rdata_o = rdata_r;
   assign applied_integ_limit_o = applied_r;
   assign general_interrupt_output_o = irq_r;
   assign calibration_enable_o = cal_en_r;
   assign trimming_enable_o = trim_en_r;

   // ***********************************************
   // checks
   // ***********************************************
   sequence s_event_seen;
      soft_rst;
   endsequence

   sequence s_defaults_held;
      intg_r == `VCSM_INTG_W'(`VCSM_INTG_RST) && mask_r == `VCSM_MASK_W'(`VCSM_MASK_RST);
   endsequence

   property p_event_defaults;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_event_seen |=> s_defaults_held;
   endproperty
   a_event_defaults: assert property (p_event_defaults) else $error("event reset missed");

   property p_steady_apply;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      hw_feedback_mode_i && !loop_transient_i
      |=> applied_r == $past(intg_r[`VCSM_STEADY_HI:`VCSM_STEADY_LO]);
   endproperty
   a_steady_apply: assert property (p_steady_apply) else $error("steady limit not applied");

   property p_trans_apply;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      hw_feedback_mode_i && loop_transient_i
      |=> applied_r == $past(intg_r[`VCSM_TRANS_HI:`VCSM_TRANS_LO]);
   endproperty
   a_trans_apply: assert property (p_trans_apply) else $error("transient limit not applied");

   property p_avg_read;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      avg_valid_i ##1 !avg_valid_i ##1 (reg_rd_i && reg_addr_i == VCSM_REG_AVG && !avg_valid_i)
      |=> reg_rdata_o == {9'h000, $past(average_current_code_i, 3)};
   endproperty
   a_avg_read: assert property (p_avg_read) else $error("average readback wrong");

   property p_inst_read;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      inst_valid_i ##1 !inst_valid_i ##1 (reg_rd_i && reg_addr_i == VCSM_REG_INST && !inst_valid_i)
      |=> reg_rdata_o == {8'h00, $past(instant_current_value_i, 3)};
   endproperty
   a_inst_read: assert property (p_inst_read) else $error("instant readback wrong");

   property p_meas_kept;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      soft_rst && !avg_valid_i && !inst_valid_i |=> $stable(avg_r) && $stable(inst_r);
   endproperty
   a_meas_kept: assert property (p_meas_kept) else $error("readback lost on event");

   property p_timeout_read;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      reg_rd_i && reg_addr_i == VCSM_REG_PWMS
      |=> reg_rdata_o[`VCSM_PERIOD_TIMEOUT_FLAG_BIT] == $past(per_if.timeout) && reg_rdata_o[19] == 1'b0;
   endproperty
   a_timeout_read: assert property (p_timeout_read) else $error("timeout bit wrong");

   property p_ro_write;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      reg_wr_i && reg_addr_i == VCSM_REG_AVG && !avg_valid_i |=> $stable(avg_r);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only register written");

   property p_unused_zero;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      reg_rd_i && reg_addr_i == VCSM_REG_MASK |=> reg_rdata_o[19:16] == 4'h0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero");

   property p_thermal_mask;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      fault_s == 16'h8000 && gpo_irq_enable_i |=> irq_r == !$past(mask_r[`VCSM_MASK_TW]);
   endproperty
   a_thermal_mask: assert property (p_thermal_mask) else $error("thermal gate wrong");

   property p_irq_or;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      1'b1 |=> irq_r == ($past(gpo_irq_enable_i) && |($past(fault_s) & ~$past(mask_r) & IRQ_BITS));
   endproperty
   a_irq_or: assert property (p_irq_or) else $error("interrupt or wrong");

   property p_crc_cal;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      fault_s[`VCSM_MASK_CRC_CSA] && !mask_r[`VCSM_MASK_CRC_CSA] |=> !cal_en_r;
   endproperty
   a_crc_cal: assert property (p_crc_cal) else $error("calibration not disabled");

   property p_crc_trim;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      mask_r[`VCSM_MASK_CRC_CONV] |=> trim_en_r;
   endproperty
   a_crc_trim: assert property (p_crc_trim) else $error("trim blocked while masked");

endmodule

`default_nettype wire

// >>> testbench/vcsm_host_model.sv
// host side model: drives the strobed register port of the channel slice
// assumes the slice runs on core_clk_i and holds read data until the next read
`timescale 1ns/10ps
`default_nettype none
`include "vcsm_defs.svh"

module vcsm_host_model
   import vcsm_pkg::*;
(
   // clock
   input wire logic core_clk_i,
   // register port
   output logic [`VCSM_ADDR_W-1:0] reg_addr_o,
   output logic reg_wr_o,
   output logic [`VCSM_WORD_W-1:0] reg_wdata_o,
   output logic reg_rd_o,
   input wire logic [`VCSM_WORD_W-1:0] reg_rdata_i
);
   initial
   begin
      reg_addr_o = 4'h0;
      reg_wr_o = 1'b0;
      reg_wdata_o = 20'h00000;
      reg_rd_o = 1'b0;
   end

   task automatic wr(input logic [3:0] a, input vcsm_word_type d);
      @(posedge core_clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_o <= 1'b0;
      // stale data must not look valid once the strobe is gone
      reg_wdata_o <= ~d;
   endtask

   // read data lands one edge after the strobe and stands, so it is taken an edge later
   task automatic rd(input logic [3:0] a, output vcsm_word_type d);
      @(posedge core_clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_o <= 1'b0;
      @(posedge core_clk_i);
      d = reg_rdata_i;
   endtask
endmodule

`default_nettype wire

// >>> testbench/vcsm_regs_tb_top.sv
// self-checking bench of the valve channel status and mask slice
// assumes the host model drives the register port; all else is driven here
`timescale 1ns/10ps
`default_nettype none
`include "vcsm_defs.svh"

module vcsm_regs_tb_top
   import vcsm_pkg::*;
;
   logic core_clk_i;
   logic rst_n_i;
   logic [3:0] addr;
   logic wr_s;
   logic rd_s;
   vcsm_word_type wdata;
   vcsm_word_type rdata;
   logic [2:0] evt;
   logic hw_mode;
   logic transient;
   logic avg_valid;
   logic [10:0] avg_code;
   logic inst_valid;
   logic [11:0] inst_val;
   logic [3:0] limit;
   logic pwm;
   logic [15:0] fault;
   logic irq_en;
   logic irq;
   logic cal;
   logic trim;
   int mismatches;
   int num_checks;

   always #12.5 core_clk_i = ~core_clk_i;

   vcsm_host_model i_vcsm_host_model (.core_clk_i(core_clk_i), .reg_addr_o(addr),
      .reg_wr_o(wr_s), .reg_wdata_o(wdata), .reg_rd_o(rd_s), .reg_rdata_i(rdata));

   vcsm_regs i_vcsm_regs (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
      .reg_wr_i(wr_s), .reg_wdata_i(wdata), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
      .battery_undervoltage_event_i(evt[0]), .ground_loss_event_i(evt[1]),
      .primary_reset_event_i(evt[2]), .hw_feedback_mode_i(hw_mode),
      .loop_transient_i(transient), .avg_valid_i(avg_valid),
      .average_current_code_i(avg_code), .inst_valid_i(inst_valid),
      .instant_current_value_i(inst_val), .applied_integ_limit_o(limit),
      .pwm_sense_i(pwm), .fault_event_i(fault), .gpo_irq_enable_i(irq_en),
      .general_interrupt_output_o(irq), .calibration_enable_o(cal),
      .trimming_enable_o(trim));

   // ****************************************
   // checking helpers
   // ****************************************
   task automatic check(input string what, input vcsm_word_type seen, input vcsm_word_type exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bchk(input string what, input logic seen, input logic exp);
      check(what, {19'h00000, seen}, {19'h00000, exp});
   endtask

   task automatic rc(input logic [3:0] a, input vcsm_word_type exp);
      vcsm_word_type d;
      i_vcsm_host_model.rd(a, d);
      check($sformatf("register %h", a), d, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask

   // 8 toggles give 4 full periods of 2*h cycles
   task automatic pwm_run(input int h);
      repeat (8)
      begin
         cyc(h);
         pwm <= ~pwm;
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ****************************************
   // tests
   // ****************************************
   initial
   begin
      core_clk_i = 1'b0;
      rst_n_i = 1'b0;
      evt = 3'h0;
      hw_mode = 1'b0;
      transient = 1'b0;
      avg_valid = 1'b0;
      avg_code = 11'h000;
      inst_valid = 1'b0;
      inst_val = 12'h000;
      pwm = 1'b0;
      fault = 16'h0000;
      irq_en = 1'b1;
      mismatches = 0;
      num_checks = 0;
      cyc(6);
      rst_n_i <= 1'b1;
      rc(4'h8, 20'h00091);
      rc(4'h9, 20'h00000);
      rc(4'ha, 20'h00000);
      rc(4'hb, 20'h04000);
      rc(4'hc, 20'h09fff);
      rc(4'h3, 20'h00000);
      i_vcsm_host_model.wr(4'h8, 20'hfffa5);
      rc(4'h8, 20'h000a5);
      hw_mode <= 1'b1;
      cyc(3);
      check("steady limit", {16'h0000, limit}, 20'h0000a);
      transient <= 1'b1;
      cyc(3);
      check("transient limit", {16'h0000, limit}, 20'h00005);
      hw_mode <= 1'b0;
      cyc(3);
      check("limit off", {16'h0000, limit}, 20'h00000);
      for (int i = 0; i < 3; i++)
      begin
         i_vcsm_host_model.wr(4'h9 + 4'(i), 20'hfffff);
      end
      rc(4'h9, 20'h00000);
      rc(4'ha, 20'h00000);
      rc(4'hb, 20'h04000);
      avg_code <= 11'h5a3;
      avg_valid <= 1'b1;
      inst_val <= 12'hf9c;
      cyc(1);
      avg_valid <= 1'b0;
      rc(4'h9, 20'h005a3);
      inst_valid <= 1'b1;
      cyc(1);
      inst_valid <= 1'b0;
      rc(4'ha, 20'h00f9c);
      // a write while the event is held must be lost as well
      for (int e = 0; e < 3; e++)
      begin
         i_vcsm_host_model.wr(4'h8, 20'h00042);
         i_vcsm_host_model.wr(4'hc, 20'h00123);
         evt[e] <= 1'b1;
         cyc(4);
         i_vcsm_host_model.wr(4'hc, 20'h00001);
         cyc(1);
         evt[e] <= 1'b0;
         cyc(3);
         rc(4'h8, 20'h00091);
         rc(4'hc, 20'h09fff);
         rc(4'h9, 20'h005a3);
      end
      for (int i = 0; i < 16; i++)
      begin
         i_vcsm_host_model.wr(4'hc, 20'h00000);
         fault <= 16'h0001 << i;
         cyc(5);
         bchk("irq", irq, (i != 13 && i != 14));
         bchk("cal", cal, (i != 14));
         bchk("trim", trim, (i != 13));
         i_vcsm_host_model.wr(4'hc, 20'h00001 << i);
         cyc(5);
         bchk("irq masked", irq, 1'b0);
         bchk("cal masked", cal, 1'b1);
         bchk("trim masked", trim, 1'b1);
      end
      i_vcsm_host_model.wr(4'hc, 20'h00000);
      irq_en <= 1'b0;
      cyc(5);
      bchk("irq disabled", irq, 1'b0);
      fault <= 16'h0000;
      pwm_run(40);
      rc(4'hb, 20'h00010);
      pwm_run(10);
      rc(4'hb, 20'h40004);
      pwm_run(40);
      rc(4'hb, 20'h00010);
      // leave the flag set so that power-on reset has something to clear
      pwm_run(10);
      rst_n_i <= 1'b0;
      cyc(2);
      rst_n_i <= 1'b1;
      rc(4'h9, 20'h00000);
      rc(4'ha, 20'h00000);
      rc(4'hb, 20'h04000);
      wrap_up();
   end

   initial
   begin
      cyc(20000);
      mismatches++;
      $display("watchdog expired before the tests ended");
      wrap_up();
   end
endmodule

`default_nettype wire
